//--- verilog/xpc_pkg.sv
// Package: constants for the crosspoint configuration host controller
package xpc_pkg;
	// APB register offsets (byte addresses)
	localparam logic [7:0] XPC_OFF_CMD = 8'h00;
	localparam logic [7:0] XPC_OFF_DATA = 8'h04;
	localparam logic [7:0] XPC_OFF_STATUS = 8'h08;
	localparam logic [7:0] XPC_OFF_RDATA = 8'h0c;
	// Command codes in CMD[2:0]
	localparam logic [2:0] XPC_CMD_WRITE = 3'h1;
	localparam logic [2:0] XPC_CMD_UPDATE = 3'h2;
	localparam logic [2:0] XPC_CMD_READ = 3'h3;
	localparam logic [2:0] XPC_CMD_RESET = 3'h4;
	// Field positions in DATA
	localparam int XPC_SEL_LSB = 0;
	localparam int XPC_EN_BIT = 6;
	localparam int XPC_ADDR_LSB = 8;
	// Device geometry
	localparam int XPC_NUM_OUT = 17;
	localparam int XPC_NUM_IN = 33;
	localparam logic [4:0] XPC_ADDR_ALL = 5'h11;
	localparam logic [4:0] XPC_ADDR_MAX = 5'h10;
	// Timing figures in ns, and clock period
	localparam int XPC_CLK_NS = 5;
	localparam int XPC_T_STRB_NS = 15;
	localparam int XPC_T_WHU_NS = 10;
	localparam int XPC_T_READ_NS = 30;
	localparam int XPC_T_REL_NS = 30;
	// Cycle counts: least times round up
	localparam logic [3:0] XPC_STRB_CYC = 4'((XPC_T_STRB_NS + XPC_CLK_NS - 1) / XPC_CLK_NS);
	localparam logic [3:0] XPC_WHU_CYC = 4'((XPC_T_WHU_NS + XPC_CLK_NS - 1) / XPC_CLK_NS);
	localparam logic [3:0] XPC_READ_CYC = 4'((XPC_T_READ_NS + XPC_CLK_NS - 1) / XPC_CLK_NS);
	localparam logic [3:0] XPC_REL_CYC = 4'((XPC_T_REL_NS + XPC_CLK_NS - 1) / XPC_CLK_NS);
	// Reset values
	localparam logic [31:0] XPC_DATA_RST = 32'h0000_0000;
	// Sequencer states
	typedef enum logic [2:0]
	{
		XPC_IDLE = 3'b000,
		XPC_SETUP = 3'b001,
		XPC_STROBE = 3'b010,
		XPC_HOLD = 3'b011,
		XPC_RELEASE = 3'b100
	} xpc_state_t;
endpackage

//--- verilog/xpc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module xpc_sync
#(
	parameter int W = 7
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Async input and synchronised output
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// Only the second flop reads the first
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule // xpc_sync
`default_nettype wire

//--- verilog/xpc_ctrl.sv
// Host controller driving the crosspoint configuration pins from APB
// What this block does
// - Five-bit select bus picks output row
// - Data bits five..zero carry input index
// - Host releases data bus during readback
// - Host returns write strobe high afterwards
// - Host writes all rows before update
// - Read and write never overlap; bus released between
// - Operations need chip select low, not reset
// - Pulse reset on command, for power-up on shared buses
// - Disable old driver before enabling new
`timescale 1ns/1ps
`default_nettype none
module xpc_ctrl
	import xpc_pkg::*;
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Device control pins, all active low except addr
	output logic [4:0] out_sel,
	output logic chip_sel_n,
	output logic first_rank_write_n,
	output logic update_n,
	output logic second_rank_read_enable_n,
	output logic xpt_reset_n,
	// Bidirectional data bus split into three signals
	input wire logic [6:0] data_in,
	output logic [6:0] data_out,
	output logic data_oe
);
	////////////////////////////////////////////////////////////////////////
	// Registers and state
	xpc_state_t state_ff;
	xpc_state_t nxt_state;
	logic [2:0] cmd_ff;
	logic [31:0] data_ff;
	logic [6:0] rdata_ff;
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic busy_ff;
	logic err_ff;
	logic done_ff;
	logic [6:0] data_sync;
	logic start;
	logic apb_wr;
	logic apb_rd;
	logic wr_start;
	logic all_rows_written;
	logic [XPC_NUM_OUT-1:0] row_hit;
	logic [XPC_NUM_OUT-1:0] row_written_ff;
	logic [3:0] turn_ff;

	// Decode of a valid command code
	function automatic logic cmd_valid(input logic [2:0] c);
		cmd_valid = (c == XPC_CMD_WRITE) || (c == XPC_CMD_UPDATE) ||
			(c == XPC_CMD_READ) || (c == XPC_CMD_RESET);
	endfunction

	// Decode of whether a select code reaches a row; the broadcast code reaches all
	function automatic logic row_match(input logic [4:0] sel, input int idx);
		row_match = (sel == XPC_ADDR_ALL) || (sel == 5'(idx));
	endfunction

	// Readback data comes from a pin, so synchronise it first
	xpc_sync #(.W(7)) u_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.async_in(data_in),
		.sync_out(data_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !penable && !pwrite;
	assign start = apb_wr && (paddr == XPC_OFF_CMD) && !busy_ff && cmd_valid(pwdata[2:0])
		&& !(pwdata[2:0] == XPC_CMD_UPDATE && !all_rows_written);
	assign wr_start = start && (pwdata[2:0] == XPC_CMD_WRITE);

	// Data register: only writable when idle so pins never glitch mid-cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			data_ff <= XPC_DATA_RST;
		else if (apb_wr && paddr == XPC_OFF_DATA && !busy_ff)
			data_ff <= pwdata;
	end

	// Command latch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cmd_ff <= 3'h0;
		else if (start)
			cmd_ff <= pwdata[2:0];
	end

	////////////////////////////////////////////////////////////////////////
	// First-rank bookkeeping: an update before every row is loaded
	// would copy undefined words into the outputs, so it is refused
	genvar gi;
	generate
		for (gi = 0; gi < XPC_NUM_OUT; gi++)
		begin : g_row
			assign row_hit[gi] = row_match(data_ff[XPC_ADDR_LSB +: 5], gi);
		end
	endgenerate
	assign all_rows_written = &row_written_ff;

	// Our reset cannot tell power-up from a soft reset, so it forgets every row
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			row_written_ff <= '0;
		else if (wr_start)
			row_written_ff <= row_written_ff | row_hit;
	end

	// Sticky error on command refused while busy, bad code or update before all rows written; write 1 clears
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			err_ff <= 1'b0;
		else if (apb_wr && paddr == XPC_OFF_CMD && !start)
			err_ff <= 1'b1;
		else if (apb_wr && paddr == XPC_OFF_STATUS && pwdata[1])
			err_ff <= 1'b0;
	end

	// Read data mux registered in setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (apb_rd)
		begin
			case (paddr)
				XPC_OFF_CMD: prdata <= {29'h0, cmd_ff};
				XPC_OFF_DATA: prdata <= data_ff;
				XPC_OFF_STATUS: prdata <= {29'h0, done_ff, err_ff, busy_ff};
				XPC_OFF_RDATA: prdata <= {25'h0, rdata_ff};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin sequencer
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			XPC_IDLE:
				if (start)
				begin
					nxt_state = XPC_SETUP;
					nxt_cnt = 4'h1;
				end
			XPC_SETUP:
			begin
				nxt_state = XPC_STROBE;
				nxt_cnt = (cmd_ff == XPC_CMD_READ) ? XPC_READ_CYC : XPC_STRB_CYC;
			end
			XPC_STROBE:
				if (cnt_ff <= 4'h1)
				begin
					nxt_state = XPC_HOLD;
					nxt_cnt = (cmd_ff == XPC_CMD_READ) ? XPC_REL_CYC : XPC_WHU_CYC;
				end
				else
					nxt_cnt = cnt_ff - 4'h1;
			XPC_HOLD:
				if (cnt_ff <= 4'h1)
					nxt_state = XPC_RELEASE;
				else
					nxt_cnt = cnt_ff - 4'h1;
			XPC_RELEASE:
				nxt_state = XPC_IDLE;
			default:
				nxt_state = XPC_IDLE;
		endcase
	end

	// State and counter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= XPC_IDLE;
			cnt_ff <= 4'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// Busy and done flags; done is set on finish, cleared by a new start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			busy_ff <= (nxt_state != XPC_IDLE) || (turn_ff != 4'h0);
			if (state_ff == XPC_RELEASE)
				done_ff <= 1'b1;
			else if (start)
				done_ff <= 1'b0;
		end
	end

	// Bus turnaround: the device may still drive D for the release time after
	// read enable rises, so the next command waits it out instead of contending
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			turn_ff <= 4'h0;
		else if (state_ff == XPC_HOLD && nxt_state == XPC_RELEASE && cmd_ff == XPC_CMD_READ)
			turn_ff <= XPC_REL_CYC;
		else if (turn_ff != 4'h0)
			turn_ff <= turn_ff - 4'h1;
	end

	// Capture readback at end of the read window (synchroniser latency absorbed)
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata_ff <= 7'h00;
		else if (cmd_ff == XPC_CMD_READ && state_ff == XPC_HOLD && cnt_ff == 4'h1)
			rdata_ff <= data_sync;
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drivers, all registered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			chip_sel_n <= 1'b1;
			first_rank_write_n <= 1'b1;
			update_n <= 1'b1;
			second_rank_read_enable_n <= 1'b1;
			xpt_reset_n <= 1'b1;
			out_sel <= 5'h00;
			data_out <= 7'h00;
			data_oe <= 1'b0;
		end
		else
		begin
			// Reset needs no chip select, so it never asserts it
			chip_sel_n <= !((nxt_state != XPC_IDLE) && (cmd_ff != XPC_CMD_RESET || start)
				&& !(start ? pwdata[2:0] == XPC_CMD_RESET : cmd_ff == XPC_CMD_RESET));
			// Strobes are level pulses that always return high
			first_rank_write_n <= !(nxt_state == XPC_STROBE && cmd_ff == XPC_CMD_WRITE);
			update_n <= !(nxt_state == XPC_STROBE && cmd_ff == XPC_CMD_UPDATE);
			// Reset pulse lets software park this part before another drives a shared bus
			xpt_reset_n <= !(nxt_state == XPC_STROBE && cmd_ff == XPC_CMD_RESET);
			second_rank_read_enable_n <= !((nxt_state == XPC_STROBE || nxt_state == XPC_HOLD)
				&& cmd_ff == XPC_CMD_READ);
			// Address from DATA[12:8]; 10001 broadcasts to every row
			out_sel <= data_ff[XPC_ADDR_LSB +: 5];
			// Selector and enable straight from DATA[6:0]
			data_out <= data_ff[XPC_SEL_LSB +: 7];
			// Drive only for writes; released through readback and its release time
			data_oe <= (nxt_state != XPC_IDLE) && (cmd_ff == XPC_CMD_WRITE)
				&& !(start && pwdata[2:0] != XPC_CMD_WRITE);
		end
	end
endmodule // xpc_ctrl
`default_nettype wire

//--- bench/xpc_ctrl_assertions.sv
// Checker for the crosspoint pin sequencing
`timescale 1ns/1ps
`default_nettype none
module xpc_ctrl_chk
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Device pins
	input wire logic [4:0] out_sel,
	input wire logic chip_sel_n,
	input wire logic first_rank_write_n,
	input wire logic update_n,
	input wire logic second_rank_read_enable_n,
	input wire logic xpt_reset_n,
	input wire logic [6:0] data_out,
	input wire logic data_oe
);
	// Short aliases keep the properties readable
	wire logic wr_n = first_rank_write_n;
	wire logic rd_n = second_rank_read_enable_n;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////
	a_wr_width: assert property ($fell(wr_n) |-> !wr_n[*3] ##1 wr_n)
		else $error("write strobe width wrong");
	a_up_width: assert property ($fell(update_n) |-> (!update_n && wr_n)[*3] ##1 update_n)
		else $error("update strobe width wrong");
	a_rst_pulse: assert property ($fell(xpt_reset_n) |-> (!xpt_reset_n && chip_sel_n)[*3] ##1 xpt_reset_n)
		else $error("reset pulse wrong");
	a_rd_width: assert property ($fell(rd_n) |-> ##11 !rd_n ##1 rd_n)
		else $error("read enable width wrong");
	a_wr_select: assert property (!wr_n |-> !chip_sel_n && data_oe)
		else $error("write strobe without select or drive");
	a_rd_release: assert property (!rd_n |-> !chip_sel_n && !data_oe)
		else $error("host drives bus during readback");
	a_wr_stable: assert property ($fell(wr_n) |-> ($stable(out_sel) && $stable(data_out))[*4])
		else $error("bus moved under write strobe");
	a_up_select: assert property (!update_n |-> !chip_sel_n && rd_n)
		else $error("update without select");
	a_rd_turnaround: assert property ($rose(rd_n) |-> (!data_oe)[*6])
		else $error("host drove bus inside read release time");
endmodule // xpc_ctrl_chk
bind xpc_ctrl xpc_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .out_sel(out_sel),
	.chip_sel_n(chip_sel_n), .first_rank_write_n(first_rank_write_n), .update_n(update_n),
	.second_rank_read_enable_n(second_rank_read_enable_n), .xpt_reset_n(xpt_reset_n),
	.data_out(data_out), .data_oe(data_oe));
`default_nettype wire

//--- bench/xpc_dev_model.sv
// Behavioural model of the double-rank latch bank
`timescale 1ns/1ps
`default_nettype none
module xpc_dev_model
(
	// Control pins
	input wire logic [4:0] sel,
	input wire logic cs_n,
	input wire logic we_n,
	input wire logic up_n,
	input wire logic re_n,
	input wire logic rs_n,
	// Split data bus
	input wire logic [6:0] dout,
	input wire logic oe,
	output logic [6:0] din
);
	logic [6:0] r1 [17];
	logic [6:0] r2 [17];
	logic [6:0] last = 7'h0;
	wire logic rd = !cs_n && !re_n;
	wire logic [6:0] bus = oe ? dout : din;
	// Transparent first rank; codes stored as written
	always @(cs_n, we_n, sel, bus)
		if (!cs_n && !we_n)
			for (int i = 0; i < 17; i++)
				if (sel == 5'h11 || sel == i)
					r1[i] = bus;
	// Reset only clears enables; select never gates it
	always @(cs_n, up_n, rs_n)
		for (int i = 0; i < 17; i++)
			if (!rs_n)
				r2[i][6] = 1'b0;
			else if (!cs_n && !up_n)
				r2[i] = r1[i];
	// Released bus shows inverse of last word, so stale reads fail
	always @(rd, sel)
		if (rd)
			last = r2[sel];
	assign din = rd ? r2[sel] : ~last;
endmodule // xpc_dev_model
`default_nettype wire

//--- bench/xpc_ctrl_test.sv
// Testbench for the crosspoint host controller
`timescale 1ns/1ps
`default_nettype none
module xpc_ctrl_test;
	import xpc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, cs_n, we_n, up_n, re_n, rs_n, oe;
	logic [4:0] sel;
	logic [6:0] dout, din;
	int errors = 0, samples_checked = 0, n;
	logic [4:0] ra [3] = '{5'h00, 5'h10, 5'h05};
	logic [6:0] rw [3] = '{7'h60, 7'h07, 7'h7f};
	initial forever #2.5 pclk = ~pclk;
	xpc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .out_sel(sel), .chip_sel_n(cs_n), .first_rank_write_n(we_n),
		.update_n(up_n), .second_rank_read_enable_n(re_n), .xpt_reset_n(rs_n),
		.data_in(din), .data_out(dout), .data_oe(oe));
	xpc_dev_model u_dev (.sel(sel), .cs_n(cs_n), .we_n(we_n), .up_n(up_n), .re_n(re_n),
		.rs_n(rs_n), .dout(dout), .oe(oe), .din(din));
	////////////////////////////////////////
	// Verdict and comparison
	task conclude;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			errors++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask
	// One APB transfer; never assumes the wait length
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		for (n = 0; pready !== 1'b1; n++)
		begin
			if (n > 50)
			begin
				errors++;
				conclude;
			end
			@(posedge pclk);
		end
		q = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	// Bounded busy poll; last status word left in q
	task wait_idle;
		for (int k = 0; k < 60; k++)
		begin
			apb(0, XPC_OFF_STATUS, 32'h0);
			if (q[0] === 1'b0)
				return;
		end
		errors++;
		conclude;
	endtask
	// Command then wait until idle
	task cmd(input logic [2:0] c, input logic [31:0] d);
		apb(1, XPC_OFF_DATA, d);
		apb(1, XPC_OFF_CMD, {29'h0, c});
		wait_idle;
	endtask
	task row(input logic [4:0] a);
		cmd(XPC_CMD_READ, {19'h0, a, 8'h0});
		apb(0, XPC_OFF_RDATA, 32'h0);
	endtask
	////////////////////////////////////////
	// Bad code check, then rows, then the awkward cases
	initial
	begin
		repeat (5) @(posedge pclk);
		chk("reset pins", {cs_n, we_n, up_n, re_n, rs_n, oe, |prdata}, 7'h7c);
		presetn <= 1;
		apb(1, XPC_OFF_CMD, 32'h0000_0005);
		apb(0, XPC_OFF_STATUS, 32'h0000_0000);
		chk("bad code refused", q, 32'h0000_0002);
		chk("apb response", {pready, pslverr}, 2'h2);
		apb(1, XPC_OFF_STATUS, 32'h0000_0002);
		apb(0, XPC_OFF_STATUS, 32'h0000_0000);
		chk("error cleared", q, 32'h0000_0000);
		cmd(XPC_CMD_RESET, 32'h0);
		cmd(XPC_CMD_WRITE, {19'h0, XPC_ADDR_ALL, 8'h47});
		for (int i = 0; i < 3; i++)
			cmd(XPC_CMD_WRITE, {19'h0, ra[i], 1'b0, rw[i]});
		cmd(XPC_CMD_UPDATE, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			row(ra[i]);
			chk("row word", q, {25'h0, rw[i]});
		end
		row(5'h01);
		chk("broadcast", q, 32'h47);
		apb(1, XPC_OFF_DATA, 32'h0000_0212);
		apb(1, XPC_OFF_CMD, {29'h0, XPC_CMD_WRITE});
		apb(1, XPC_OFF_CMD, {29'h0, XPC_CMD_UPDATE});
		apb(1, XPC_OFF_DATA, 32'h0000_0000);
		wait_idle;
		chk("busy refusal", q, 32'h0000_0006);
		apb(0, XPC_OFF_DATA, 32'h0000_0000);
		chk("data kept while busy", q, 32'h0000_0212);
		apb(1, XPC_OFF_STATUS, 32'h0000_0002);
		row(5'h02);
		chk("refused update", q, 32'h0000_0047);
		cmd(XPC_CMD_WRITE, 32'h41);
		row(5'h00);
		chk("second rank held", q, 32'h60);
		cmd(XPC_CMD_RESET, 32'h0);
		row(5'h05);
		chk("enable cleared", q, 32'h3f);
		cmd(XPC_CMD_UPDATE, 32'h0);
		row(5'h00);
		chk("first rank kept", q, 32'h41);
		apb(0, 8'h10, 32'h0);
		chk("unmapped", q, 32'h0);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		chk("mid reset pins", {cs_n, we_n, up_n, re_n, rs_n, oe, |prdata}, 7'h7c);
		presetn <= 1;
		cmd(XPC_CMD_UPDATE, 32'h0000_0000);
		chk("update before rows", q, 32'h0000_0002);
		conclude;
	end
endmodule // xpc_ctrl_test
`default_nettype wire
